//--- logic/lcd_segment_driver.sv
// apb controlled multiplexed segment display driver
//
// Summary of operation
// - drives up to 27 frontplanes and 4 backplanes: 26x4, 27x3 or 27x1.
// - one pin is frontplane 0 or backplane 3, chosen by the duty field.
// - frontplanes 19-26 go to display by low and high port option bits.
// - fourteen data registers, two frontplanes each, the last only one; 1 turns segment on.
// - disabled means every output at supply level and ladder disconnected.
// - static uses backplane 0, 1/3 uses three, 1/4 uses all four.
// - while enabled the backplane waveforms of the duty run continuously.
// - bias 1/3 with four levels: supply, two thirds, one third, bias.
// - reference clock divided by 3-bit select gives the waveform base clock.
// - one frame spans as many base clock periods as the duty has slots.
// - low-current bit switches ladder resistors to the high value.
// - fast-charge uses low resistance briefly after each waveform edge.
// - fast-charge window is base period over 32, 64 or 128.
// - 4-bit contrast selects one of sixteen bias levels.
// - waveforms keep running in wait mode.
// - with oscillator-in-stop set, the display keeps running in stop mode.
// - otherwise the driver halts in stop and resumes on wake-up.
// - stop mode leaves every register unchanged.
// - duty code 00 static, 01 third, 10 quarter; 11 unused.
// - window per half period is base/32, /64, /128 for codes 00, 01, 10.
// - low-current 0 gives low value, 01 high value, both set fast-charge.
// - enable bit is read/write and cleared by reset.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module lcd_segment_driver (
  // apb clock and reset
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  // apb slave
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [lcd_segment_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  // reference clock pin and low-power state
  input  wire logic                                crystal_ref_clock,
  input  wire logic                                stop_mode,
  // display drive level codes
  output logic      [5:0]                          backplane_outputs,
  output logic      [1:0]                          shared_front_back_pin,
  output logic      [51:0]                         frontplane_outputs,
  // port c pin ownership
  output logic                                     portc_low_display_sel,
  output logic                                     portc_high_display_sel,
  // analogue ladder control
  output logic                                     ladder_connect,
  output logic                                     ladder_resistor_low,
  output logic      [3:0]                          contrast_sel
);
  import lcd_segment_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic                               driver_enable_bit;
    logic                               fast_charge_sel;
    logic                               low_current_sel;
    logic [3:0]                         contrast_sel;
    logic [1:0]                         fast_charge_len_sel;
    logic [1:0]                         duty_sel;
    logic [2:0]                         base_clock_div_sel;
    logic                               portc_low_display_sel;
    logic                               portc_high_display_sel;
    logic                               osc_run_in_stop;
    logic [SEG_REGS-1:0][SEG_BITS-1:0]  segment_data_regs;
    logic                               xsync1;
    logic                               xsync2;
    logic                               xsync3;
    logic                               xlevel;
    logic [PHASE_W-1:0]                 phase;
    logic [1:0]                         slot;
    logic [31:0]                        rdata;
    logic [BP_COUNT-1:0][1:0]           bp_lvl;
    logic [FP_COUNT-1:0][1:0]           fp_lvl;
    logic                               ladder_on;
    logic                               ladder_low;
  } state_type;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_CTRL,
    SEL_CLK,
    SEL_OPT,
    SEL_STAT,
    SEL_SEG
  } sel_type;

  state_type state_r;
  state_type state_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic sel_type decode(input logic [ADDR_W-1:0] a);
    sel_type s;
    s = SEL_NONE;
    if (a == CTRL_OFS) begin
      s = SEL_CTRL;
    end else if (a == CLKSEL_OFS) begin
      s = SEL_CLK;
    end else if (a == OPTION_OFS) begin
      s = SEL_OPT;
    end else if (a == STATUS_OFS) begin
      s = SEL_STAT;
    end else if (a >= SEG_BASE_OFS && a < SEG_BASE_OFS + ADDR_W'(4 * SEG_REGS) && a[1:0] == 2'h0) begin
      s = SEL_SEG;
    end
    return s;
  endfunction

  function automatic logic [3:0] seg_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - SEG_BASE_OFS;
    return d[5:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // waveform timing signals

  logic [PHASE_W-1:0]      period_mask;
  logic [PHASE_W-1:0]      half_mask;
  logic [PHASE_W-1:0]      half_pos;
  logic [PHASE_W-1:0]      window_last;
  logic [2:0]              window_shift;
  logic                    half;
  logic                    fc_window;
  logic                    halted;
  logic                    ref_tick;
  logic [1:0]              last_slot;
  logic [FP_COUNT-1:0][1:0] fp_level;
  sel_type                 sel;

  always_comb begin
    // base period is 2^(select+7) reference ticks
    period_mask = PHASE_ALL >> (LCLK_MAX - state_r.base_clock_div_sel);
    half_mask   = period_mask >> 1;
    half        = |(state_r.phase & ~half_mask);
    half_pos    = state_r.phase & half_mask;
    unique case (state_r.fast_charge_len_sel)
      FCLEN_32:  window_shift = FCLEN_SHIFT_BASE;
      FCLEN_64:  window_shift = FCLEN_SHIFT_BASE + 3'h1;
      FCLEN_128: window_shift = FCLEN_SHIFT_BASE + 3'h2;
      default:   window_shift = FCLEN_SHIFT_BASE + 3'h2;
    endcase
    window_last = period_mask >> window_shift;
    fc_window   = half_pos <= window_last;
    unique case (state_r.duty_sel)
      DUTY_THIRD:   last_slot = LAST_SLOT_THIRD;
      DUTY_QUARTER: last_slot = LAST_SLOT_QUARTER;
      default:      last_slot = 2'h0;
    endcase
    // wait mode leaves the reference running
    halted   = stop_mode && !state_r.osc_run_in_stop;
    ref_tick = state_r.xsync2 == state_r.xsync3 && state_r.xsync3 && !state_r.xlevel;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // frontplane level generators

  genvar g;
  generate
    for (g = 0; g < FP_COUNT; g++) begin : g_fp
      frontplane_level u_level (
        .duty     (state_r.duty_sel),
        .slot     (state_r.slot),
        .half     (half),
        .seg_bits (state_r.segment_data_regs[g / 2][(g % 2) * 4 +: 4]),
        .level    (fp_level[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_nxt = state_r;
    sel       = decode(paddr);

    // reference pin, three stages
    state_nxt.xsync1 = crystal_ref_clock;
    state_nxt.xsync2 = state_r.xsync1;
    state_nxt.xsync3 = state_r.xsync2;
    if (state_r.xsync2 == state_r.xsync3) begin
      state_nxt.xlevel = state_r.xsync3;
    end

    // register writes, kept in stop
    if (psel && penable && pwrite) begin
      unique case (sel)
        SEL_CTRL: begin
          state_nxt.driver_enable_bit = pwdata[CTRL_EN_BIT];
          state_nxt.fast_charge_sel   = pwdata[CTRL_FC_BIT];
          state_nxt.low_current_sel   = pwdata[CTRL_LC_BIT];
          state_nxt.contrast_sel      = pwdata[CTRL_CON_LSB +: 4];
        end
        SEL_CLK: begin
          state_nxt.fast_charge_len_sel = pwdata[CLK_FCCTL_LSB +: 2];
          state_nxt.duty_sel            = pwdata[CLK_DUTY_LSB +: 2];
          state_nxt.base_clock_div_sel  = pwdata[CLK_LCLK_LSB +: 3];
        end
        SEL_OPT: begin
          state_nxt.portc_low_display_sel  = pwdata[OPT_PCL_BIT];
          state_nxt.portc_high_display_sel = pwdata[OPT_PCH_BIT];
          state_nxt.osc_run_in_stop        = pwdata[OPT_OSCS_BIT];
        end
        SEL_SEG: begin
          state_nxt.segment_data_regs[seg_index(paddr)] = pwdata[SEG_BITS-1:0];
        end
        default: begin
        end
      endcase
    end

    // read data captured in the setup cycle
    if (psel && !penable) begin
      state_nxt.rdata = RD_ZERO;
      unique case (sel)
        SEL_CTRL: begin
          state_nxt.rdata[CTRL_EN_BIT]      = state_r.driver_enable_bit;
          state_nxt.rdata[CTRL_FC_BIT]      = state_r.fast_charge_sel;
          state_nxt.rdata[CTRL_LC_BIT]      = state_r.low_current_sel;
          state_nxt.rdata[CTRL_CON_LSB +: 4] = state_r.contrast_sel;
        end
        SEL_CLK: begin
          state_nxt.rdata[CLK_FCCTL_LSB +: 2] = state_r.fast_charge_len_sel;
          state_nxt.rdata[CLK_DUTY_LSB +: 2]  = state_r.duty_sel;
          state_nxt.rdata[CLK_LCLK_LSB +: 3]  = state_r.base_clock_div_sel;
        end
        SEL_OPT: begin
          state_nxt.rdata[OPT_PCL_BIT]  = state_r.portc_low_display_sel;
          state_nxt.rdata[OPT_PCH_BIT]  = state_r.portc_high_display_sel;
          state_nxt.rdata[OPT_OSCS_BIT] = state_r.osc_run_in_stop;
        end
        SEL_STAT: begin
          state_nxt.rdata[ST_SLOT_LSB +: 2] = state_r.slot;
          state_nxt.rdata[ST_HALF_BIT]      = half;
          state_nxt.rdata[ST_FCW_BIT]       = fc_window;
          state_nxt.rdata[ST_RUN_BIT]       = state_r.driver_enable_bit && !halted;
        end
        SEL_SEG: begin
          state_nxt.rdata[SEG_BITS-1:0] = state_r.segment_data_regs[seg_index(paddr)];
        end
        default: begin
        end
      endcase
    end

    // base clock phase and frame slot
    if (!state_r.driver_enable_bit) begin
      state_nxt.phase = '0;
      state_nxt.slot  = 2'h0;
    end else if (ref_tick && !halted) begin
      if (state_r.phase >= period_mask) begin
        state_nxt.phase = '0;
        // a frame is one base period per slot
        state_nxt.slot = (state_r.slot >= last_slot) ? 2'h0 : state_r.slot + 2'h1;
      end else begin
        state_nxt.phase = state_r.phase + PHASE_W'(1);
      end
    end

    // backplane levels
    for (int b = 0; b < BP_COUNT; b++) begin
      if (!state_r.driver_enable_bit || 2'(b) > last_slot) begin
        state_nxt.bp_lvl[b] = LVL_FULL;
      end else if (2'(b) == state_r.slot) begin
        state_nxt.bp_lvl[b] = half ? LVL_BIAS : LVL_FULL;
      end else begin
        state_nxt.bp_lvl[b] = half ? LVL_TWO3 : LVL_ONE3;
      end
    end

    // frontplane levels
    for (int f = 0; f < FP_COUNT; f++) begin
      state_nxt.fp_lvl[f] = state_r.driver_enable_bit ? fp_level[f] : LVL_FULL;
    end

    // ladder resistor select
    state_nxt.ladder_on = state_r.driver_enable_bit;
    if (!state_r.low_current_sel) begin
      state_nxt.ladder_low = 1'b1;
    end else if (state_r.fast_charge_sel) begin
      state_nxt.ladder_low = fc_window;
    end else begin
      state_nxt.ladder_low = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r                        <= '0;
      state_r.driver_enable_bit      <= 1'b0;
      state_r.contrast_sel           <= CON_RESET;
      state_r.duty_sel               <= DUTY_STATIC;
      state_r.fast_charge_len_sel    <= FCLEN_32;
      state_r.rdata                  <= RD_ZERO;
      state_r.bp_lvl                 <= '0;
      state_r.fp_lvl                 <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    pready  = 1'b1;
    pslverr = psel && penable && (decode(paddr) == SEL_NONE ||
              (pwrite && decode(paddr) == SEL_STAT));
    prdata  = state_r.rdata;
    for (int b = 0; b < 3; b++) begin
      backplane_outputs[b * 2 +: 2] = state_r.bp_lvl[b];
    end
    // shared pin is backplane 3 only in quarter duty
    shared_front_back_pin = (state_r.duty_sel == DUTY_QUARTER) ?
                            state_r.bp_lvl[3] : state_r.fp_lvl[0];
    for (int f = 1; f < FP_COUNT; f++) begin
      frontplane_outputs[(f - 1) * 2 +: 2] = state_r.fp_lvl[f];
    end
    portc_low_display_sel  = state_r.portc_low_display_sel;
    portc_high_display_sel = state_r.portc_high_display_sel;
    ladder_connect         = state_r.ladder_on;
    ladder_resistor_low    = state_r.ladder_low;
    contrast_sel           = state_r.contrast_sel;
  end
endmodule

//--- logic/lcd_segment_pkg.sv
// constants, register map and waveform codes of the segment display driver
package lcd_segment_pkg;
  // apb register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] CLKSEL_OFS    = 8'h04;
  localparam logic [7:0] OPTION_OFS    = 8'h08;
  localparam logic [7:0] STATUS_OFS    = 8'h0C;
  localparam logic [7:0] SEG_BASE_OFS  = 8'h10;
  localparam int         SEG_REGS      = 14;
  localparam int         SEG_BITS      = 8;
  localparam int         FP_COUNT      = 27;
  localparam int         BP_COUNT      = 4;
  localparam int         ADDR_W        = 8;
  // control register fields
  localparam int CTRL_EN_BIT  = 7;
  localparam int CTRL_FC_BIT  = 6;
  localparam int CTRL_LC_BIT  = 5;
  localparam int CTRL_CON_LSB = 0;
  // clock select register fields
  localparam int CLK_FCCTL_LSB = 6;
  localparam int CLK_DUTY_LSB  = 3;
  localparam int CLK_LCLK_LSB  = 0;
  // option register fields
  localparam int OPT_PCL_BIT  = 0;
  localparam int OPT_PCH_BIT  = 1;
  localparam int OPT_OSCS_BIT = 2;
  // status register fields
  localparam int ST_SLOT_LSB = 0;
  localparam int ST_HALF_BIT = 2;
  localparam int ST_FCW_BIT  = 3;
  localparam int ST_RUN_BIT  = 4;
  // duty codes
  localparam logic [1:0] DUTY_STATIC  = 2'h0;
  localparam logic [1:0] DUTY_THIRD   = 2'h1;
  localparam logic [1:0] DUTY_QUARTER = 2'h2;
  // last slot index per duty
  localparam logic [1:0] LAST_SLOT_THIRD   = 2'h2;
  localparam logic [1:0] LAST_SLOT_QUARTER = 2'h3;
  // fast-charge length codes
  localparam logic [1:0] FCLEN_32  = 2'h0;
  localparam logic [1:0] FCLEN_64  = 2'h1;
  localparam logic [1:0] FCLEN_128 = 2'h2;
  localparam logic [2:0] FCLEN_SHIFT_BASE = 3'h5;
  // drive level codes: full supply, two thirds, one third, contrast bias
  localparam logic [1:0] LVL_FULL  = 2'h0;
  localparam logic [1:0] LVL_TWO3  = 2'h1;
  localparam logic [1:0] LVL_ONE3  = 2'h2;
  localparam logic [1:0] LVL_BIAS  = 2'h3;
  // base clock divider: ratio is 2^(select + 7) reference ticks
  localparam int          PHASE_W     = 14;
  localparam logic [13:0] PHASE_ALL   = 14'h3FFF;
  localparam logic [2:0]  LCLK_MAX    = 3'h7;
  // reset values
  localparam logic [31:0] RD_ZERO     = 32'h0000_0000;
  localparam logic [3:0]  CON_RESET   = 4'h0;
endpackage

//--- logic/frontplane_level.sv
// drive level of one frontplane for the current slot and half period
`timescale 1ns/1ps
module frontplane_level (
  // waveform position
  input  wire logic [1:0] duty,
  input  wire logic [1:0] slot,
  input  wire logic       half,
  // segment bits of this frontplane, one per backplane
  input  wire logic [3:0] seg_bits,
  // resulting level code
  output logic      [1:0] level
);
  import lcd_segment_pkg::*;

  logic on_bit;

  always_comb begin
    on_bit = seg_bits[slot];
    if (duty == DUTY_QUARTER || duty == DUTY_THIRD) begin
      // on: full span, off: one third
      if (on_bit) begin
        level = half ? LVL_FULL : LVL_BIAS;
      end else begin
        level = half ? LVL_ONE3 : LVL_TWO3;
      end
    end else begin
      // static: on antiphase, off in phase
      if (seg_bits[0]) begin
        level = half ? LVL_FULL : LVL_BIAS;
      end else begin
        level = half ? LVL_BIAS : LVL_FULL;
      end
    end
  end
endmodule

//--- sim/lcd_segment_chk.sv
// concurrent checks on the segment display driver ports
`timescale 1ns/1ps
module lcd_segment_chk (
  // clock and reset
  input wire logic                               pclk,
  input wire logic                               presetn,
  // apb request and low-power state
  input wire logic                               psel,
  input wire logic                               penable,
  input wire logic                               pwrite,
  input wire logic [lcd_segment_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                        pwdata,
  input wire logic                               pready,
  input wire logic                               stop_mode,
  // display and ladder side
  input wire logic [5:0]                         backplane_outputs,
  input wire logic [1:0]                         shared_front_back_pin,
  input wire logic [51:0]                        frontplane_outputs,
  input wire logic                               portc_low_display_sel,
  input wire logic                               portc_high_display_sel,
  input wire logic                               ladder_connect,
  input wire logic                               ladder_resistor_low,
  input wire logic [3:0]                         contrast_sel
);
  import lcd_segment_pkg::*;
  logic [7:0] ctrl_r, clk_r, opt_r;
  logic [1:0] age_r, stab_r, stop_r;
  logic       wr_acc;
  assign wr_acc = psel && penable && pwrite && pready;
  ////////////////////////////////////////////////////////////////////////////////
  // configuration shadow and counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 8'h00;
      clk_r  <= 8'h00;
      opt_r  <= 8'h00;
      age_r  <= 2'h0;
      stab_r <= 2'h0;
      stop_r <= 2'h0;
    end else begin
      age_r  <= age_r + {1'b0, age_r != 2'h3};
      stab_r <= stab_r + {1'b0, stab_r != 2'h3};
      stop_r <= stop_mode ? stop_r + {1'b0, stop_r != 2'h3} : 2'h0;
      if (wr_acc && paddr == CTRL_OFS) begin
        ctrl_r <= pwdata[7:0];
        stab_r <= 2'h0;
      end
      if (wr_acc && paddr == CLKSEL_OFS) begin
        clk_r  <= pwdata[7:0];
        stab_r <= 2'h0;
      end
      if (wr_acc && paddr == OPTION_OFS) begin
        opt_r  <= pwdata[7:0];
        stab_r <= 2'h0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  blank_when_off_a: assert property (
    (!ladder_connect) [*2] |-> backplane_outputs == 6'h00 && frontplane_outputs == '0 && shared_front_back_pin == 2'h0)
    else $error("outputs not blank");
  enable_follow_a: assert property (
    wr_acc && paddr == CTRL_OFS |-> ##2 ladder_connect == ctrl_r[CTRL_EN_BIT])
    else $error("ladder connect not enable");
  contrast_sel_a: assert property (
    age_r == 2'h3 && stab_r >= 2'h2 |-> contrast_sel == ctrl_r[3:0])
    else $error("contrast select wrong");
  low_res_a: assert property (
    age_r == 2'h3 && stab_r >= 2'h2 && !ctrl_r[CTRL_LC_BIT] |-> ladder_resistor_low)
    else $error("ladder not low");
  high_res_a: assert property (
    stab_r >= 2'h2 && ctrl_r[CTRL_LC_BIT] && !ctrl_r[CTRL_FC_BIT] |-> !ladder_resistor_low)
    else $error("ladder not high");
  static_unused_a: assert property (
    stab_r >= 2'h2 && clk_r[4:3] == DUTY_STATIC |-> backplane_outputs[5:2] == 4'h0)
    else $error("unused backplane driven");
  portc_owner_a: assert property (
    stab_r >= 2'h2 |-> portc_low_display_sel == opt_r[OPT_PCL_BIT] && portc_high_display_sel == opt_r[OPT_PCH_BIT])
    else $error("port c select wrong");
  stop_freeze_a: assert property (
    stop_mode && stop_r >= 2'h2 && !opt_r[OPT_OSCS_BIT] && stab_r >= 2'h2 |->
      $stable(backplane_outputs) && $stable(frontplane_outputs) && $stable(shared_front_back_pin))
    else $error("waveforms move in stop");
  cover property (ctrl_r[6:5] == 2'h3 && $rose(ladder_resistor_low));
  cover property (stop_mode && stop_r == 2'h3);
  cover property (clk_r[4:3] == DUTY_QUARTER && shared_front_back_pin == LVL_BIAS);
endmodule

//--- sim/lcd_panel_model.sv
// passive segment panel: flags segments that see the full drive span
`timescale 1ns/1ps
module lcd_panel_model (
  // clock and flag clear
  input  wire logic       pclk,
  input  wire logic       clear,
  // panel wiring
  input  wire logic       quarter,
  // drive level codes
  input  wire logic [5:0] bp_lvl,
  input  wire logic [1:0] shared_lvl,
  input  wire logic [1:0] fp1_lvl,
  // [3:0] front 0, [7:4] front 1
  output logic      [7:0] seen_on
);
  import lcd_segment_pkg::*;
  logic [1:0] bp [4];
  function automatic logic full_span(input logic [1:0] a, input logic [1:0] b);
    return (a == LVL_FULL && b == LVL_BIAS) || (a == LVL_BIAS && b == LVL_FULL);
  endfunction
  always_comb begin
    for (int b = 0; b < 3; b++) bp[b] = bp_lvl[2*b +: 2];
    bp[3] = shared_lvl;
  end
  always @(posedge pclk) begin
    if (clear) seen_on <= 8'h00;
    else for (int b = 0; b < 4; b++) begin
      if (!quarter && b < 3 && full_span(bp[b], shared_lvl)) seen_on[b] <= 1'b1;
      if ((quarter || b < 3) && full_span(bp[b], fp1_lvl)) seen_on[4+b] <= 1'b1;
    end
  end
endmodule

//--- sim/lcd_segment_driver_tb_top.sv
// self-checking bench of the segment display driver
`timescale 1ns/1ps
module lcd_segment_driver_tb_top;
  import lcd_segment_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, stop_mode, clear, quarter;
  logic        pready, pslverr, pcl, pch, lconn, llow, err_v, xref;
  logic [1:0]  shared, ref_cnt = 2'h0;
  logic [3:0]  con;
  logic [5:0]  bp;
  logic [7:0]  paddr, seen;
  logic [31:0] pwdata, prdata, rd_v, st_v;
  logic [51:0] fp;
  logic [7:0]  fr_clk [4] = '{8'h00, 8'h08, 8'h10, 8'h01};
  logic [7:0]  fc_ctl [6] = '{8'hE0, 8'hE0, 8'hE0, 8'hE0, 8'hA0, 8'h80};
  int          num_errors, checks, cyc;
  assign xref = ref_cnt[1];
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) ref_cnt <= ref_cnt + 2'h1;
  lcd_segment_driver dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_ref_clock(xref), .stop_mode(stop_mode), .backplane_outputs(bp), .shared_front_back_pin(shared),
    .frontplane_outputs(fp), .portc_low_display_sel(pcl), .portc_high_display_sel(pch),
    .ladder_connect(lconn), .ladder_resistor_low(llow), .contrast_sel(con));
  lcd_panel_model panel (.pclk(pclk), .clear(clear), .quarter(quarter), .bp_lvl(bp), .shared_lvl(shared),
    .fp1_lvl(fp[1:0]), .seen_on(seen));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] seen_v, input logic [63:0] exp);
    checks++;
    if (seen_v !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen_v);
    end
  endtask
  task automatic apb(input logic wr_en, input logic [7:0] addr, input logic [31:0] data);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr_en;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd_v = prdata;
    err_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      check("apb ready", pready, 64'h1);
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wait_bp0(input logic want, inout int n);
    while ((bp[1:0] == LVL_BIAS) != want && n < 6000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic frame_len(output int len);
    int n, m;
    n = 0;
    wait_bp0(1'b0, n);
    wait_bp0(1'b1, n);
    m = n;
    wait_bp0(1'b0, n);
    wait_bp0(1'b1, n);
    len = n - m;
    if (n >= 6000) begin
      check("frame wait", 64'h0, 64'h1);
      final_report();
    end
  endtask
  task automatic panel_run(input int n);
    repeat (4) @(posedge pclk);
    clear <= 1'b1;
    @(posedge pclk);
    clear <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int s;
    {pclk, presetn, psel, penable, pwrite, stop_mode, quarter} = 7'h00;
    clear = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    num_errors = 0;
    checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(8'(4 * i));
      check("reset value", rd_v, 64'(i == 3) << ST_FCW_BIT);
    end
    check("blank drive", {bp, shared, fp, lconn}, 64'h0);
    rd(8'h48);
    check("unmapped read", {err_v, rd_v}, 64'h1_0000_0000);
    for (int k = 0; k < SEG_REGS; k++) wr(SEG_BASE_OFS + 8'(4 * k), 8'h5A ^ 8'(k));
    for (int k = 0; k < SEG_REGS; k++) begin
      rd(SEG_BASE_OFS + 8'(4 * k));
      check("segment bits", rd_v, 64'(8'h5A ^ 8'(k)));
    end
    wr(OPTION_OFS, 8'h03);
    repeat (3) @(posedge pclk);
    check("port c select", {pch, pcl}, 64'h3);
    $display("test registers done");
    wr(CTRL_OFS, 8'h80);
    for (int i = 0; i < 4; i++) begin
      wr(CLKSEL_OFS, fr_clk[i]);
      frame_len(cyc);
      s = (fr_clk[i][4:3] == DUTY_THIRD) ? 3 : (fr_clk[i][4:3] == DUTY_QUARTER) ? 4 : 1;
      check("frame length", cyc, 64'(4 * (128 << fr_clk[i][2:0]) * s));
    end
    $display("test frames done");
    wr(SEG_BASE_OFS, 8'h21);
    wr(CLKSEL_OFS, 8'h08);
    panel_run(3200);
    check("third duty segments", seen, 64'h21);
    wr(SEG_BASE_OFS, 8'h80);
    wr(CLKSEL_OFS, 8'h10);
    quarter <= 1'b1;
    panel_run(4200);
    check("quarter duty segments", seen, 64'h80);
    $display("test panel done");
    for (int i = 0; i < 6; i++) begin
      wr(CLKSEL_OFS, (i < 4) ? {2'(i), 6'h08} : 8'h08);
      wr(CTRL_OFS, fc_ctl[i]);
      repeat (4) @(posedge pclk);
      cyc = 0;
      repeat (1024) begin
        @(posedge pclk);
        cyc += (llow === 1'b1);
      end
      s = (i == 5) ? 1024 : (i == 4) ? 0 : 16 * (128 >> (5 + ((i == 3) ? 2 : i)));
      check("low resistance cycles", cyc, 64'(s));
    end
    wr(CTRL_OFS, 8'h8F);
    repeat (3) @(posedge pclk);
    check("contrast", con, 64'hF);
    $display("test ladder done");
    wr(OPTION_OFS, 8'h03);
    stop_mode <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(STATUS_OFS);
    st_v = rd_v;
    repeat (700) @(posedge pclk);
    rd(STATUS_OFS);
    check("frozen status", rd_v, st_v);
    rd(SEG_BASE_OFS);
    check("retained segment", rd_v, 64'h80);
    stop_mode <= 1'b0;
    repeat (700) @(posedge pclk);
    rd(STATUS_OFS);
    check("status resumes", 64'(rd_v !== st_v), 64'h1);
    wr(OPTION_OFS, 8'h07);
    stop_mode <= 1'b1;
    rd(STATUS_OFS);
    st_v = rd_v;
    repeat (700) @(posedge pclk);
    rd(STATUS_OFS);
    check("status runs in stop", 64'(rd_v !== st_v), 64'h1);
    stop_mode <= 1'b0;
    wr(CTRL_OFS, 8'h00);
    stop_mode <= 1'b1;
    repeat (4) @(posedge pclk);
    check("blank in stop", {bp, shared, fp, lconn}, 64'h0);
    $display("test stop done");
    final_report();
  end
endmodule
bind lcd_segment_driver lcd_segment_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .stop_mode(stop_mode),
  .backplane_outputs(backplane_outputs), .shared_front_back_pin(shared_front_back_pin),
  .frontplane_outputs(frontplane_outputs), .portc_low_display_sel(portc_low_display_sel),
  .portc_high_display_sel(portc_high_display_sel), .ladder_connect(ladder_connect),
  .ladder_resistor_low(ladder_resistor_low), .contrast_sel(contrast_sel));
